/* File: design/dii_top.sv */
`timescale 1ns/1ps
// Summary of operation
// (R1) Two independent filtered binary input channels
// (R2) Input byte: bit0 channel zero, bit1 one
// (R3) No output bytes consumed
// (R4) CANopen master reads byte at 5000h
// (R5) EtherCAT uses 6000h plus slot, 01h/02h
// (R6) State changes appear 3 ms after input
// (R7) Channel lamp lit while state is one
// (R8) Channel lamps work without electronics supply
// (R9) Run green, fault dark when all OK
// (R10) Fault lamp steady on module error
// (R11) Bus lost plus error: run off, fault on
// (R12) Bus power failure: both lamps dark
// (R13) Configuration error flashes fault lamp
// (R14) Reserved bits always read zero
// (R15) Synchronise inputs; short pulses are rejected
// (R16) Reset clears filters and reports zero
module dii_top
  import dii_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = DII_FILTER_CYCLES,
  parameter int unsigned FLASH_CYCLES = DII_FLASH_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_input_channel_zero,
  input wire logic i_input_channel_one,
  input wire logic i_bus_comm_ok,
  input wire logic i_module_error,
  input wire logic i_config_error,
  input wire logic i_bus_power_ok,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  output logic [DII_NUM_CH-1:0] o_channel_lamp,
  output logic o_run_lamp,
  output logic o_module_fault_lamp
);
  // ---------------------------------------------------------------
  // Input filters
  // ---------------------------------------------------------------
  logic [DII_NUM_CH-1:0] raw;
  logic [DII_NUM_CH-1:0] state;

  assign raw[DII_CH0_BIT] = i_input_channel_zero;
  assign raw[DII_CH1_BIT] = i_input_channel_one;

  // One filter per channel, each independent
  genvar g;
  generate
    for (g = 0; g < DII_NUM_CH; g++) begin : g_ch
      dii_filter #(
        .CYCLES(FILTER_CYCLES)
      ) u_filter (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_raw(raw[g]),
        .o_state(state[g]) // [R1]
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Input image read port
  // ---------------------------------------------------------------
  logic [7:0] image;
  logic hit;
  logic [7:0] next_rd_data;

  // Channel bits low, reserved bits forced to zero
  assign image = {6'h00, state}; // [R2] [R14]
  assign hit = i_rd_addr == DII_INPUT_STATE_BYTE_OFS;
  assign next_rd_data = (i_rd_en && hit) ? image : 8'h00;

  // Registered read data, zero for unmapped addresses
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rd_data <= DII_INPUT_STATE_RESET;
    end else begin
      o_rd_data <= next_rd_data; // [R2]
    end
  end

  // Output area writes are accepted and dropped
  logic wr_unused;
  assign wr_unused = i_wr_en & (|i_wr_addr) & (|i_wr_data); // [R3]

  // ---------------------------------------------------------------
  // Bus power and status synchronisers
  // ---------------------------------------------------------------
  logic [3:0] st_a;
  logic [3:0] st_b;
  logic comm_ok;
  logic mod_err;
  logic cfg_err;
  logic pwr_ok;

  // Status levels arrive from outside the clock domain
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_a <= 4'h0;
      st_b <= 4'h0;
    end else begin
      st_a <= {i_bus_power_ok, i_config_error, i_module_error,
               i_bus_comm_ok};
      st_b <= st_a;
    end
  end

  assign comm_ok = st_b[0];
  assign mod_err = st_b[1];
  assign cfg_err = st_b[2];
  assign pwr_ok = st_b[3];

  // ---------------------------------------------------------------
  // Flash divider
  // ---------------------------------------------------------------
  localparam int unsigned FW = $clog2(FLASH_CYCLES + 1);
  localparam logic [FW-1:0] FLAST = FW'(FLASH_CYCLES - 1);
  logic [FW-1:0] flash_cnt;
  logic flash_tick;
  logic flash_phase;

  assign flash_tick = flash_cnt == FLAST;

  // Toggle the blink phase once per flash interval
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      flash_cnt <= '0;
      flash_phase <= 1'b0;
    end else if (flash_tick) begin
      flash_cnt <= '0;
      flash_phase <= ~flash_phase; // [R13]
    end else begin
      flash_cnt <= flash_cnt + FW'(1);
    end
  end

  // ---------------------------------------------------------------
  // Lamp mode selection
  // ---------------------------------------------------------------
  dii_lamp_t mode;
  dii_lamp_t next_mode;

  // Power loss outranks configuration, then module error
  always_comb begin
    next_mode = DII_LAMP_OK;
    if (!pwr_ok) begin
      next_mode = DII_LAMP_NOPWR; // [R12]
    end else if (cfg_err) begin
      next_mode = DII_LAMP_CFG; // [R13]
    end else if (mod_err) begin
      next_mode = DII_LAMP_FAULT; // [R10]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode <= DII_LAMP_NOPWR;
    end else begin
      mode <= next_mode;
    end
  end

  logic next_run;
  logic next_fault;

  // Lamp outputs per mode
  always_comb begin
    next_run = 1'b0;
    next_fault = 1'b0;
    case (mode)
      DII_LAMP_OK: begin
        next_run = comm_ok; // [R9]
        next_fault = 1'b0; // [R9]
      end
      DII_LAMP_FAULT: begin
        next_run = comm_ok; // [R11]
        next_fault = 1'b1; // [R10]
      end
      DII_LAMP_CFG: begin
        next_run = comm_ok; // [R13]
        next_fault = flash_phase; // [R13]
      end
      DII_LAMP_NOPWR: begin
        next_run = 1'b0; // [R12]
        next_fault = 1'b0; // [R12]
      end
      default: begin
        next_run = 1'b0;
        next_fault = 1'b0;
      end
    endcase
  end

  // Registered lamp drivers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_run_lamp <= 1'b0;
      o_module_fault_lamp <= 1'b0;
      o_channel_lamp <= '0;
    end else begin
      o_run_lamp <= next_run;
      o_module_fault_lamp <= next_fault;
      // Channel lamps ignore bus power state
      o_channel_lamp <= state; // [R7] [R8]
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_lamp_follows;
    @(posedge i_sys_clk) disable iff (i_rst)
      1 |=> (o_channel_lamp == $past(state));
  endproperty
  a_lamp_follows: assert property (p_lamp_follows) // [R7]
    else $error("channel lamp does not follow state");

  property p_lamp_nopwr;
    @(posedge i_sys_clk) disable iff (i_rst)
      (!$past(i_rst) && !pwr_ok) |=> ##1 (!o_run_lamp && !o_module_fault_lamp);
  endproperty
  a_lamp_nopwr: assert property (p_lamp_nopwr) // [R12]
    else $error("lamps lit during bus power failure");

  property p_lamp_ok;
    @(posedge i_sys_clk) disable iff (i_rst)
      (pwr_ok && !cfg_err && !mod_err && comm_ok)[*3] |->
        (o_run_lamp && !o_module_fault_lamp);
  endproperty
  a_lamp_ok: assert property (p_lamp_ok) // [R9]
    else $error("run lamp wrong in healthy state");

  property p_fault_steady;
    @(posedge i_sys_clk) disable iff (i_rst)
      (pwr_ok && !cfg_err && mod_err)[*3] |-> o_module_fault_lamp;
  endproperty
  a_fault_steady: assert property (p_fault_steady) // [R10]
    else $error("fault lamp dark on module error");

  property p_lost_comm;
    @(posedge i_sys_clk) disable iff (i_rst)
      (pwr_ok && !cfg_err && mod_err && !comm_ok)[*3] |->
        (!o_run_lamp && o_module_fault_lamp);
  endproperty
  a_lost_comm: assert property (p_lost_comm) // [R11]
    else $error("bus loss indication wrong");

  property p_cfg_flash;
    @(posedge i_sys_clk) disable iff (i_rst)
      (mode == DII_LAMP_CFG && $past(mode) == DII_LAMP_CFG)
        |-> (o_module_fault_lamp == $past(flash_phase));
  endproperty
  a_cfg_flash: assert property (p_cfg_flash) // [R13]
    else $error("fault lamp not flashing on config error");

  property p_reserved_zero;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_rd_data[7:2] == 6'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R14]
    else $error("reserved input bits not zero");

  property p_read_image;
    @(posedge i_sys_clk) disable iff (i_rst)
      (i_rd_en && hit) |=> (o_rd_data[1:0] == $past(state));
  endproperty
  a_read_image: assert property (p_read_image) // [R2]
    else $error("input byte does not carry channel states");

  property p_read_refused;
    @(posedge i_sys_clk) disable iff (i_rst)
      !(i_rd_en && hit) |=> (o_rd_data == 8'h00);
  endproperty
  a_read_refused: assert property (p_read_refused) // [R2]
    else $error("input byte driven without a read");

  property p_nopwr_mode;
    @(posedge i_sys_clk) disable iff (i_rst)
      !pwr_ok |=> (mode == DII_LAMP_NOPWR);
  endproperty
  a_nopwr_mode: assert property (p_nopwr_mode) // [R12]
    else $error("power loss not given first place");

  property p_cfg_mode;
    @(posedge i_sys_clk) disable iff (i_rst)
      (pwr_ok && cfg_err) |=> (mode == DII_LAMP_CFG);
  endproperty
  a_cfg_mode: assert property (p_cfg_mode) // [R13]
    else $error("configuration error not selected");

  property p_cfg_run;
    @(posedge i_sys_clk) disable iff (i_rst)
      (mode == DII_LAMP_CFG) |=> (o_run_lamp == $past(comm_ok));
  endproperty
  a_cfg_run: assert property (p_cfg_run) // [R13]
    else $error("run lamp disturbed by configuration error");
endmodule

/* File: design/dii_pkg.sv */
package dii_pkg;
  // ---------------------------------------------------------------
  // Input image layout
  // ---------------------------------------------------------------
  localparam int unsigned DII_NUM_CH = 2;
  localparam logic [7:0] DII_INPUT_STATE_BYTE_OFS = 8'h00;
  localparam int unsigned DII_CH0_BIT = 0;
  localparam int unsigned DII_CH1_BIT = 1;
  localparam logic [7:0] DII_INPUT_STATE_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Field bus object mapping, used by the masters outside
  // ---------------------------------------------------------------
  localparam logic [15:0] DII_CANOPEN_OBJECT_INDEX = 16'h5000;
  localparam logic [15:0] DII_ETHERCAT_OBJECT_INDEX_BASE = 16'h6000;
  localparam logic [7:0] DII_ETHERCAT_SUBINDEX_CH0 = 8'h01;
  localparam logic [7:0] DII_ETHERCAT_SUBINDEX_CH1 = 8'h02;
  // Module identity, value is arbitrary
  localparam logic [31:0] DII_MODULE_ID = 32'h0000_0a5c;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned DII_CLK_HZ = 200_000_000;
  localparam int unsigned DII_FILTER_US = 3000;
  localparam int unsigned DII_FILTER_CYCLES =
    (DII_CLK_HZ / 1_000_000) * DII_FILTER_US;
  localparam int unsigned DII_FLASH_MS = 250;
  localparam int unsigned DII_FLASH_CYCLES =
    (DII_CLK_HZ / 1000) * DII_FLASH_MS;
  // Lamp indication modes
  typedef enum logic [1:0] {
    DII_LAMP_OK,
    DII_LAMP_FAULT,
    DII_LAMP_CFG,
    DII_LAMP_NOPWR
  } dii_lamp_t;
endpackage

/* File: design/dii_filter.sv */
`timescale 1ns/1ps
module dii_filter
  import dii_pkg::*;
#(
  parameter int unsigned CYCLES = DII_FILTER_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_raw,
  output logic o_state
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic sync_a;
  logic sync_b;
  logic [CW-1:0] cnt;
  logic differs;
  logic expired;

  // Two-stage synchroniser on the raw pin
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= i_raw; // [R15]
      sync_b <= sync_a; // [R15]
    end
  end

  assign differs = sync_b != o_state;
  assign expired = differs && (cnt == LAST);

  // Count while the input disagrees; any return restarts the wait
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt <= '0; // [R16]
      o_state <= 1'b0; // [R16]
    end else if (!differs) begin
      cnt <= '0; // [R15]
    end else if (expired) begin
      cnt <= '0;
      o_state <= sync_b; // [R6]
    end else begin
      cnt <= cnt + CW'(1); // [R6]
    end
  end

  // Reported state moves only after a full stable interval
  // The pin may move again on the edge that updates the state, so the
  // settled value is taken from the cycle that made the decision
  property p_hold_stable;
    @(posedge i_sys_clk) disable iff (i_rst)
      (!$past(i_rst) && o_state != $past(o_state)) |->
        ($past(cnt) == LAST && $past(sync_b) == o_state);
  endproperty
  a_hold_stable: assert property (p_hold_stable) // [R6]
    else $error("filter output changed without settling");

  property p_glitch_blocked;
    @(posedge i_sys_clk) disable iff (i_rst)
      (!differs) |=> (cnt == '0);
  endproperty
  a_glitch_blocked: assert property (p_glitch_blocked) // [R15]
    else $error("filter count not cleared on agreement");
endmodule

/* File: verification/dii_coupler_model.sv */
`timescale 1ns/1ps
module dii_coupler_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_en,
  output logic [7:0] o_rd_addr,
  output logic o_wr_en,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data
);
  // Object 5000h of the coupler lands on byte +0 of this slot
  localparam logic [7:0] SLOT_OFS = 8'h00;
  // Idle bus
  initial begin
    o_rd_en = 1'b0;
    o_rd_addr = 8'h00;
    o_wr_en = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = 8'h00;
  end
  // One read, answer sampled in the cycle after the taking edge
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] d);
    @(negedge i_sys_clk);
    o_rd_en = 1'b1;
    o_rd_addr = addr;
    @(negedge i_sys_clk);
    o_rd_en = 1'b0;
    o_rd_addr = ~addr; // Released lines do not keep the old value
    d = i_rd_data;
  endtask
  // Channel read by subindex: 01h is bit 0, 02h is bit 1
  task automatic read_channel(input logic [7:0] sub, output logic bit_v);
    logic [7:0] d;
    read_byte(SLOT_OFS, d);
    bit_v = d[sub-8'h01];
  endtask
  // Output data offered to the slot, which it must not use
  task automatic write_out(input logic [7:0] addr, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_wr_en = 1'b1;
    o_wr_addr = addr;
    o_wr_data = d;
    @(negedge i_sys_clk);
    o_wr_en = 1'b0;
    o_wr_data = ~d;
  endtask
endmodule

/* File: verification/test_dii_top.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end \
end
module test_dii_top;
  import dii_pkg::*;
  localparam int unsigned FC = 20;
  localparam int unsigned LC = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] ch = 2'b00;
  logic comm = 1'b1, err = 1'b0, cfg = 1'b0, pwr = 1'b1;
  logic rd_en, wr_en, run, fault, b;
  logic [7:0] rd_addr, rd_data, wr_addr, wr_data, d;
  logic [1:0] lamp;
  int checks = 0, miscompares = 0, cycles = 0, flips;
  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  dii_top #(.FILTER_CYCLES(FC), .FLASH_CYCLES(LC)) dut (
    .i_sys_clk(clk), .i_rst(rst),
    .i_input_channel_zero(ch[0]), .i_input_channel_one(ch[1]),
    .i_bus_comm_ok(comm), .i_module_error(err),
    .i_config_error(cfg), .i_bus_power_ok(pwr),
    .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .o_channel_lamp(lamp), .o_run_lamp(run), .o_module_fault_lamp(fault));
  dii_coupler_model coupler (
    .i_sys_clk(clk), .i_rd_data(rd_data), .o_rd_en(rd_en),
    .o_rd_addr(rd_addr), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data));
  // Expected image: two channel bits, reserved bits zero
  function automatic logic [7:0] image(input logic [1:0] c);
    return {6'h00, c};
  endfunction
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check_image(input logic [1:0] c);
    coupler.read_byte(DII_INPUT_STATE_BYTE_OFS, d);
    `CHK("input byte", image(c), d)
    `CHK("channel lamps", c, lamp)
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h2c30));
    wait_cyc(2);
    rst = 1'b0;
    check_image(2'b00);
    // Random levels, stray reads and output writes
    for (int i = 0; i < 8; i++) begin
      ch = 2'($urandom);
      coupler.write_out(8'($urandom), 8'($urandom));
      coupler.read_byte(8'($urandom_range(255, 1)), d);
      `CHK("unmapped byte", 8'h00, d)
      wait_cyc(FC + 8);
      check_image(ch);
    end
    // Delay of both edges and subindex access
    ch = 2'b00;
    wait_cyc(FC + 8);
    for (int e = 0; e < 2; e++) begin
      ch[0] = ~ch[0];
      wait_cyc(FC);
      `CHK("early lamp", ~ch[0], lamp[0])
      wait_cyc(8);
      `CHK("late lamp", ch[0], lamp[0])
      coupler.read_channel(DII_ETHERCAT_SUBINDEX_CH0, b);
      `CHK("subindex ch0", ch[0], b)
    end
    // Pulse shorter than the filter
    ch[1] = 1'b1;
    wait_cyc(FC / 2);
    ch[1] = 1'b0;
    wait_cyc(FC / 2 + 4);
    `CHK("pulse lamp", 1'b0, lamp[1])
    coupler.read_channel(DII_ETHERCAT_SUBINDEX_CH1, b);
    `CHK("subindex ch1", 1'b0, b)
    wait_cyc(FC + 8);
    check_image(2'b00);
    // Every status combination
    for (int s = 0; s < 16; s++) begin
      {pwr, comm, err, cfg} = 4'(s);
      ch = 2'($urandom);
      wait_cyc(FC + 8);
      check_image(ch);
      `CHK("run lamp", pwr & comm, run)
      if (pwr && cfg) begin
        flips = 0;
        b = fault;
        for (int k = 0; k < 4 * LC; k++) begin
          wait_cyc(1);
          if (fault !== b) flips++;
          b = fault;
          `CHK("run in flash", comm, run)
        end
        `CHK("fault flashing", 1'b1, flips >= 2)
      end else begin
        `CHK("fault lamp", pwr & err, fault)
      end
    end
    // Second reset with both channels high
    ch = 2'b11;
    wait_cyc(FC + 8);
    check_image(2'b11);
    rst = 1'b1;
    wait_cyc(2);
    rst = 1'b0;
    check_image(2'b00);
    wait_cyc(FC - 6);
    `CHK("lamps after reset", 2'b00, lamp)
    wait_cyc(10);
    `CHK("lamps refilled", 2'b11, lamp)
    complete_run();
  end
endmodule
